// ===== hdl/keyboard_control.sv
// control end: frame slot timing, code capture, translation and AXI4-Lite registers
// assumes one keyboard attached on the link, same clock as the bus
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
module keyboard_control #(
  parameter int SLOT_LEN = kbd_pkg::SLOT_CYCLES,
  parameter int FRAME_LEN = kbd_pkg::FRAME_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [kbd_pkg::CHAR_W-1:0] input_data_lines,
  output logic input_data_strobe,
  output logic [2:0] format_cmd,
  output logic format_strobe,
  output logic two_position_char,
  kbd_link_if.control link
);
  import kbd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] ctrl;
  logic char_ready;
  logic char_shift;
  logic char_twopos;
  logic char_format;
  logic [CODE_W-1:0] char_code;
  logic [CHAR_W-1:0] char_internal;
  logic [1:0] slot;
  logic [31:0] status_word;

  assign status_word = {10'h000, char_internal, 1'b0, char_code, 4'h0,
                        char_format, char_twopos, char_shift, char_ready};

  ////////////////////////////////////////////////////////////////////////////////
  // bus write
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic clear_ready;

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign clear_ready = do_write && (aw_addr == STATUS_OFFSET) && w_strb[0]
                       && w_data[STAT_READY_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr == CTRL_OFFSET || aw_addr == STATUS_OFFSET
                      || aw_addr == SLOT_OFFSET) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
    end else if (do_write && aw_addr == CTRL_OFFSET) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb[i]) begin
          ctrl[i*8 +: 8] <= w_data[i*8 +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_rvalid) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        CTRL_OFFSET: s_axi_rdata <= ctrl;
        STATUS_OFFSET: s_axi_rdata <= status_word;
        SLOT_OFFSET: s_axi_rdata <= {30'h00000000, slot};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // slot timing and frame sequence
  localparam int ST_W = (SLOT_LEN > 1) ? $clog2(SLOT_LEN) : 1;
  localparam logic [ST_W-1:0] SLOT_LAST = ST_W'(SLOT_LEN - 1);
  logic [ST_W-1:0] slot_timer;
  logic [3:0] frame_count;
  ctrl_state_t state;
  logic [CODE_W-1:0] rx_code;
  logic slot_start;

  assign rx_code = {link.scan_count_bits, link.scan_count_lsb};
  assign slot_start = ctrl[CTRL_ENABLE_BIT] && (slot_timer == '0)
                      && (slot == ctrl[CTRL_KBNUM_LSB +: 2]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_timer <= '0;
      slot <= 2'h0;
    end else if (slot_timer == SLOT_LAST) begin
      slot_timer <= '0;
      slot <= slot + 1'b1;
    end else begin
      slot_timer <= slot_timer + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      frame_count <= 4'h0;
      link.keyboard_frame_pulse <= 1'b0;
      link.load_complete_ack <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          link.load_complete_ack <= 1'b0;
          if (slot_start) begin
            state <= ST_FRAME;
            frame_count <= 4'h0;
            link.keyboard_frame_pulse <= 1'b1;
          end
        end
        ST_FRAME: begin
          frame_count <= frame_count + 1'b1;
          if (link.char_available) begin
            state <= ST_ACK;
            link.keyboard_frame_pulse <= 1'b0;
            link.load_complete_ack <= 1'b1;
          end else if (frame_count == 4'(FRAME_LEN)) begin
            state <= ST_IDLE;
            link.keyboard_frame_pulse <= 1'b0;
          end
        end
        ST_ACK: begin
          state <= ST_IDLE;
          link.load_complete_ack <= 1'b0;
        end
        default: begin
          state <= ST_IDLE;
          link.keyboard_frame_pulse <= 1'b0;
          link.load_complete_ack <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // capture and translation
  logic take;
  logic is_format;
  logic is_twopos;

  assign take = (state == ST_FRAME) && link.char_available;
  assign is_format = (rx_code >= FORMAT_BASE);
  assign is_twopos = (rx_code >= TWO_POS_BASE) && !is_format;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      char_ready <= 1'b0;
      char_shift <= 1'b0;
      char_twopos <= 1'b0;
      char_format <= 1'b0;
      char_code <= CODE_RESET;
      char_internal <= '0;
    end else if (take) begin
      char_ready <= 1'b1;
      char_shift <= link.shift_level;
      char_twopos <= is_twopos;
      char_format <= is_format;
      char_code <= rx_code;
      char_internal <= rx_code[CHAR_W-1:0];
    end else if (clear_ready) begin
      char_ready <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_data_lines <= '0;
      input_data_strobe <= 1'b0;
      format_cmd <= 3'h0;
      format_strobe <= 1'b0;
      two_position_char <= 1'b0;
    end else begin
      input_data_strobe <= take && (!is_format || ctrl[CTRL_FMTMASK_LSB + rx_code[2:0]]);
      input_data_lines <= take ? rx_code[CHAR_W-1:0] : '0;
      format_strobe <= take && is_format;
      format_cmd <= take ? rx_code[2:0] : 3'h0;
      two_position_char <= take && is_twopos;
    end
  end

endmodule : keyboard_control

// ===== hdl/kbd_pkg.sv
// constants, states and register map shared by the keyboard encoder and the control end
// assumes a single 50 MHz system clock for both ends
package kbd_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int SCAN_CLOCK_HZ = 100_000;
  localparam int SCAN_DIV_CYCLES = CLK_HZ / SCAN_CLOCK_HZ;
  localparam int REPEAT_HZ = 10;
  localparam int REPEAT_DIV_CYCLES = CLK_HZ / REPEAT_HZ;
  localparam int SLOT_CYCLES = 16;
  localparam int FRAME_CYCLES = 4;
  localparam int KB_SLOTS = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // code widths and values
  localparam int CODE_W = 7;
  localparam int CHAR_W = 6;
  localparam int KEY_CODES = 128;
  localparam logic [1:0] SAMPLE_VALID = 2'h3;
  localparam logic [1:0] SAMPLE_RESET = 2'h0;
  localparam logic [6:0] TWO_POS_BASE = 7'h70;
  localparam logic [6:0] FORMAT_BASE = 7'h78;
  localparam logic [6:0] CODE_RESET = 7'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // register map, byte offsets
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] SLOT_OFFSET = 4'h8;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_KBNUM_LSB = 1;
  localparam int CTRL_FMTMASK_LSB = 8;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_SHIFT_BIT = 1;
  localparam int STAT_TWOPOS_BIT = 2;
  localparam int STAT_FORMAT_BIT = 3;
  localparam int STAT_CODE_LSB = 8;
  localparam int STAT_CHAR_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000ff00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // control end states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FRAME = 2'b01,
    ST_ACK = 2'b10
  } ctrl_state_t;

endpackage : kbd_pkg

// ===== hdl/kbd_link_if.sv
// keyboard to control unit link
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface kbd_link_if;
  logic keyboard_frame_pulse;
  logic scan_count_lsb;
  logic [5:0] scan_count_bits;
  logic shift_level;
  logic char_available;
  logic load_complete_ack;

  modport device (
    input keyboard_frame_pulse,
    input load_complete_ack,
    output scan_count_lsb,
    output scan_count_bits,
    output shift_level,
    output char_available
  );

  modport control (
    output keyboard_frame_pulse,
    output load_complete_ack,
    input scan_count_lsb,
    input scan_count_bits,
    input shift_level,
    input char_available
  );
endinterface : kbd_link_if

// ===== hdl/sync_two_ff.sv
// two flip-flop synchroniser for a bus of independent levels
// assumes each bit is a slow level, not a coherent word
`timescale 1ns/10ps
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : sync_two_ff

// ===== hdl/keyboard_encoder.sv
// keyboard end: scan counter, debounce sample counter, lockout and frame answer
// assumes key switches are asynchronous levels, the link shares aclk
//
// Overview of operation
// - scanning paced by local 100 kHz tick
// - matrix hits when count equals pressed key
// - third sample freezes scan counter on key
// - lockout set at three, blocks further sampling
// - frame pulse gates frozen code onto lines
// - char available only in frame, count three
// - ack clears samples; release then frees lockout
// - repeat key: 10 Hz pulse frees lockout
// - manual release key clears sample counter
// - shift flag sampled with each key sample, not while locked, sent
// - every ordinary key yields 7 bit code
// - control translates code to 6 bit char
// - control flags eight two-position characters
`timescale 1ns/10ps
module keyboard_encoder #(
  parameter int SCAN_DIV = kbd_pkg::SCAN_DIV_CYCLES,
  parameter int REPEAT_CYCLES = kbd_pkg::REPEAT_DIV_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [kbd_pkg::KEY_CODES-1:0] key_switch,
  input wire logic shift_key,
  input wire logic repeat_key,
  input wire logic manual_release,
  output logic keyboard_locked,
  output logic [1:0] sample_count_out,
  kbd_link_if.device link
);
  import kbd_pkg::*;

  localparam int DIV_W = (SCAN_DIV > 1) ? $clog2(SCAN_DIV) : 1;
  localparam int REP_W = (REPEAT_CYCLES > 1) ? $clog2(REPEAT_CYCLES) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCAN_DIV - 1);
  localparam logic [REP_W-1:0] REP_LAST = REP_W'(REPEAT_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisation
  logic [KEY_CODES+2:0] pins_raw;
  logic [KEY_CODES+2:0] pins_sync;
  logic [KEY_CODES-1:0] key_sync;
  logic shift_sync;
  logic repeat_sync;
  logic release_sync;

  assign pins_raw = {manual_release, repeat_key, shift_key, key_switch};

  sync_two_ff #(
    .WIDTH(KEY_CODES + 3)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  assign key_sync = pins_sync[KEY_CODES-1:0];
  assign shift_sync = pins_sync[KEY_CODES];
  assign repeat_sync = pins_sync[KEY_CODES+1];
  assign release_sync = pins_sync[KEY_CODES+2];

  ////////////////////////////////////////////////////////////////////////////////
  // local scan clock
  logic [DIV_W-1:0] div_count;
  logic scan_tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_count <= '0;
    end else if (div_count == DIV_LAST) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_tick <= 1'b0;
    end else begin
      scan_tick <= (div_count == DIV_LAST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // scan counter and matrix
  logic [CODE_W-1:0] scan_count;
  logic [1:0] sample_count;
  logic lockout_ff;
  logic matrix_hit;
  logic sample_take;
  logic scan_run;
  logic key_held;

  assign key_held = key_sync[scan_count];
  assign matrix_hit = scan_tick && key_held;
  assign sample_take = matrix_hit && !lockout_ff && (sample_count != SAMPLE_VALID);
  // stop on the tick that brings the third sample so the code stays on the key
  assign scan_run = scan_tick && !lockout_ff && (sample_count != SAMPLE_VALID)
                    && !(sample_take && (sample_count == 2'h2));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_count <= CODE_RESET;
    end else if (scan_run) begin
      scan_count <= scan_count + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sample counter
  logic clear_samples;

  assign clear_samples = link.load_complete_ack || release_sync;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_count <= SAMPLE_RESET;
    end else if (clear_samples) begin
      sample_count <= SAMPLE_RESET;
    end else if (sample_take) begin
      sample_count <= sample_count + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // repeat pulse
  logic [REP_W-1:0] repeat_count;
  logic repeat_pulse;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      repeat_count <= '0;
    end else if (!repeat_sync || (repeat_count == REP_LAST)) begin
      repeat_count <= '0;
    end else begin
      repeat_count <= repeat_count + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      repeat_pulse <= 1'b0;
    end else begin
      repeat_pulse <= repeat_sync && (repeat_count == REP_LAST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // lockout
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lockout_ff <= 1'b0;
    end else if (sample_count == SAMPLE_VALID) begin
      lockout_ff <= 1'b1;
    end else if (repeat_sync) begin
      if (repeat_pulse) begin
        lockout_ff <= 1'b0;
      end
    end else if (!key_held) begin
      lockout_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      keyboard_locked <= 1'b0;
      sample_count_out <= SAMPLE_RESET;
    end else begin
      keyboard_locked <= lockout_ff || (sample_count == SAMPLE_VALID);
      sample_count_out <= sample_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shift flag
  logic shift_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_ff <= 1'b0;
    end else if (sample_take) begin
      shift_ff <= shift_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // frame answer
  logic frame_on;

  assign frame_on = link.keyboard_frame_pulse;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.scan_count_lsb <= 1'b0;
      link.scan_count_bits <= '0;
    end else if (frame_on) begin
      link.scan_count_lsb <= scan_count[0];
      link.scan_count_bits <= scan_count[CODE_W-1:1];
    end else begin
      link.scan_count_lsb <= 1'b0;
      link.scan_count_bits <= '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.char_available <= 1'b0;
    end else begin
      link.char_available <= frame_on && (sample_count == SAMPLE_VALID);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.shift_level <= 1'b0;
    end else begin
      link.shift_level <= frame_on && shift_ff;
    end
  end

endmodule : keyboard_encoder

// ===== testbench/kbd_link_chk.sv
// assertions on the link between keyboard end and control end
// assumes one clock, synchronous active-low reset, plain link signals
`timescale 1ns/10ps
module kbd_link_chk #(
  parameter int FRAME_LEN = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic keyboard_frame_pulse,
  input wire logic scan_count_lsb,
  input wire logic [5:0] scan_count_bits,
  input wire logic shift_level,
  input wire logic char_available,
  input wire logic load_complete_ack
);
  localparam int FRAME_MAX = FRAME_LEN + 1;
  logic [6:0] code;
  assign code = {scan_count_bits, scan_count_lsb};
  default clocking link_clk @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  a_code_idle_zero: assert property (
    !$past(keyboard_frame_pulse) |-> code == 7'h00) else $error("code outside frame");
  a_avail_in_frame: assert property (
    char_available |-> $past(keyboard_frame_pulse)) else $error("avail outside frame");
  a_frame_bounded: assert property (
    $rose(keyboard_frame_pulse) |-> ##[1:FRAME_MAX] !keyboard_frame_pulse)
    else $error("frame too long");
  a_frame_ends_avail: assert property (
    char_available && keyboard_frame_pulse |=> !keyboard_frame_pulse)
    else $error("frame held after avail");
  a_frame_spacing: assert property (
    $rose(keyboard_frame_pulse) |=> (!$rose(keyboard_frame_pulse)) [*8])
    else $error("frames too close");
  a_ack_pulse: assert property (
    load_complete_ack |=> !load_complete_ack) else $error("ack longer than a cycle");
  a_ack_after_avail: assert property (
    $rose(load_complete_ack) |-> $past(char_available)) else $error("ack without avail");
  a_ack_quiet: assert property (
    load_complete_ack |=> (!char_available) [*3]) else $error("avail after ack");
  c_capture: cover property (char_available && keyboard_frame_pulse);
  c_ack: cover property (load_complete_ack);
  c_empty_frame: cover property ($fell(keyboard_frame_pulse) && !char_available);
endmodule : kbd_link_chk

// ===== testbench/tb_debounced_keyboard_encoder.sv
// bench: encoder and control end joined by the link, control driven over AXI4-Lite
// assumes package, link interface and both ends compiled first
`timescale 1ns/10ps
module tb_debounced_keyboard_encoder;
  import kbd_pkg::*;
  localparam logic [7:0] FMT_MASK = 8'hfe;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [KEY_CODES-1:0] key_switch = '0;
  logic shift_key = 1'b0, repeat_key = 1'b0, manual_release = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, sample_count_out, rs;
  logic [31:0] s_axi_rdata, rd;
  logic [CHAR_W-1:0] input_data_lines;
  logic [5:0] ids_last;
  logic [2:0] format_cmd, fmt_last;
  logic input_data_strobe, format_strobe, two_position_char, keyboard_locked;
  logic [31:0] lfsr = 32'h63a8c345;
  logic [6:0] corner [5] = '{7'h00, 7'h7f, 7'h70, 7'h77, 7'h78};
  int err_count = 0, cmp_count = 0, cyc = 0, ids_cnt = 0, fmt_cnt = 0, tp_cnt = 0;
  kbd_link_if link_if ();
  keyboard_encoder #(.SCAN_DIV(4), .REPEAT_CYCLES(50)) keyboard_encoder_inst (.aclk, .aresetn,
    .key_switch, .shift_key, .repeat_key, .manual_release, .keyboard_locked,
    .sample_count_out, .link(link_if));
  keyboard_control #(.SLOT_LEN(16), .FRAME_LEN(4)) keyboard_control_inst (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .input_data_lines, .input_data_strobe, .format_cmd, .format_strobe, .two_position_char,
    .link(link_if));
  kbd_link_chk #(.FRAME_LEN(4)) kbd_link_chk_inst (.aclk, .aresetn,
    .keyboard_frame_pulse(link_if.keyboard_frame_pulse),
    .scan_count_lsb(link_if.scan_count_lsb), .scan_count_bits(link_if.scan_count_bits),
    .shift_level(link_if.shift_level), .char_available(link_if.char_available),
    .load_complete_ack(link_if.load_complete_ack));
  always #10 aclk = ~aclk;
  ////////////////////////////////////////////////////////////
  // output monitors and timeout
  always @(posedge aclk) begin
    cyc++;
    if (input_data_strobe === 1'b1) begin
      ids_cnt++;
      ids_last = input_data_lines;
    end
    if (format_strobe === 1'b1) begin
      fmt_cnt++;
      fmt_last = format_cmd;
    end
    if (two_position_char === 1'b1) tp_cnt++;
    if (cyc == 90000) begin
      err_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next
  function automatic logic is_fmt(input logic [6:0] c);
    return c >= FORMAT_BASE;
  endfunction : is_fmt
  function automatic logic is_tp(input logic [6:0] c);
    return c[6:3] == TWO_POS_BASE[6:3];
  endfunction : is_tp
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // one key press, capture, lockout while held, release
  task automatic press(input logic [6:0] c, input logic sh);
    int i0;
    int f0;
    int t0;
    int n;
    logic ie;
    i0 = ids_cnt;
    f0 = fmt_cnt;
    t0 = tp_cnt;
    n = 0;
    ie = !is_fmt(c) || FMT_MASK[c[2:0]];
    @(posedge aclk);
    key_switch[c] <= 1'b1;
    shift_key <= sh;
    do begin
      axi_rd(STATUS_OFFSET, rd, rs);
      n++;
    end while (rd[STAT_READY_BIT] !== 1'b1 && n < 2000);
    chk("code", rd[STAT_CODE_LSB +: CODE_W], c);
    chk("char", rd[STAT_CHAR_LSB +: CHAR_W], c[5:0]);
    chk("shift", rd[STAT_SHIFT_BIT], sh);
    chk("twopos", rd[STAT_TWOPOS_BIT], is_tp(c));
    chk("format", rd[STAT_FORMAT_BIT], is_fmt(c));
    repeat (1600) @(posedge aclk);
    chk("held lock", keyboard_locked, 1'b1);
    chk("data strobes", ids_cnt - i0, ie);
    if (ie) chk("data", ids_last, c[5:0]);
    chk("fmt strobes", fmt_cnt - f0, is_fmt(c));
    if (is_fmt(c)) chk("fmt cmd", fmt_last, c[2:0]);
    chk("twopos pulses", tp_cnt - t0, is_tp(c));
    key_switch[c] <= 1'b0;
    shift_key <= 1'b0;
    repeat (10) @(posedge aclk);
    chk("free lock", keyboard_locked, 1'b0);
    axi_wr(STATUS_OFFSET, 32'h00000001, rs);
    axi_rd(STATUS_OFFSET, rd, rs);
    chk("ready clear", rd[STAT_READY_BIT], 1'b0);
  endtask : press
  ////////////////////////////////////////////////////////////
  initial begin
    int n;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(CTRL_OFFSET, rd, rs);
    chk("ctrl reset", rd, CTRL_RESET);
    axi_rd(4'hc, rd, rs);
    chk("bad rd data", rd, 32'h0);
    chk("bad rd resp", rs, RESP_SLVERR);
    axi_wr(4'hc, 32'hffffffff, rs);
    chk("bad wr resp", rs, RESP_SLVERR);
    // frames still off: lock, then free by manual release
    @(posedge aclk);
    key_switch[7'h25] <= 1'b1;
    n = 0;
    while (keyboard_locked !== 1'b1 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    chk("count three", sample_count_out, SAMPLE_VALID);
    repeat (600) @(posedge aclk);
    chk("no frame data", ids_cnt, 0);
    chk("still frozen", sample_count_out, SAMPLE_VALID);
    key_switch[7'h25] <= 1'b0;
    repeat (20) @(posedge aclk);
    chk("lock without ack", keyboard_locked, 1'b1);
    manual_release <= 1'b1;
    repeat (10) @(posedge aclk);
    manual_release <= 1'b0;
    repeat (10) @(posedge aclk);
    chk("manual free", {keyboard_locked, sample_count_out}, 3'h0);
    lfsr = lfsr_next(lfsr);
    axi_wr(CTRL_OFFSET, {16'h0000, FMT_MASK, 5'h00, lfsr[1:0], 1'b1}, rs);
    chk("ctrl resp", rs, RESP_OKAY);
    axi_rd(CTRL_OFFSET, rd, rs);
    chk("ctrl", rd, {16'h0000, FMT_MASK, 5'h00, lfsr[1:0], 1'b1});
    axi_rd(SLOT_OFFSET, rd, rs);
    chk("slot resp", rs, RESP_OKAY);
    chk("slot high", rd[31:2], 30'h0);
    foreach (corner[k]) press(corner[k], k[0]);
    repeat (4) begin
      lfsr = lfsr_next(lfsr);
      press(lfsr[6:0], lfsr[7]);
    end
    n = ids_cnt;
    @(posedge aclk);
    key_switch[7'h41] <= 1'b1;
    repeat_key <= 1'b1;
    repeat (5000) @(posedge aclk);
    chk("repeats", (ids_cnt - n) >= 2, 1'b1);
    key_switch[7'h41] <= 1'b0;
    repeat_key <= 1'b0;
    repeat (200) @(posedge aclk);
    chk("idle", keyboard_locked, 1'b0);
    finish_test();
  end
endmodule : tb_debounced_keyboard_encoder
